// ==== common/asc_defines.vh ====
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

`define ASC_ADDR_W 14
`define ASC_DATA_W 4
`define ASC_CLK_NS 10

// Grade timings in ns, fast grade first and slow grade second.
`define ASC_T_RC_FAST 25
`define ASC_T_RC_SLOW 35
`define ASC_T_OE_FAST 12
`define ASC_T_OE_SLOW 15
`define ASC_T_CHZ_FAST 12
`define ASC_T_CHZ_SLOW 20
`define ASC_T_OHZ 10
`define ASC_T_WP_FAST 20
`define ASC_T_WP_SLOW 30
`define ASC_T_DW_FAST 12
`define ASC_T_DW_SLOW 20
`define ASC_T_WHZ_FAST 8
`define ASC_T_WHZ_SLOW 10
`define ASC_T_WR 0
`define ASC_T_OW 5

// Least times round up to whole cycles, none below one.
`define ASC_CYC_MIN(t) ((((t) + `ASC_CLK_NS - 1) / `ASC_CLK_NS) < 1 ? 1 : \
    (((t) + `ASC_CLK_NS - 1) / `ASC_CLK_NS))

`endif

// ==== core/asc_host.v ====
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.vh"
// Host controller that runs read and write cycles on the asynchronous memory pins.
module asc_host (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Grade select, high for the slow grade
    input wire slow_grade,
    // Supply state, low while the memory supply is dropped
    input wire supply_ok,
    // User request
    input wire req_valid,
    input wire req_write,
    input wire [`ASC_ADDR_W-1:0] req_addr,
    input wire [`ASC_DATA_W-1:0] req_wdata,
    output wire req_ready,
    // User answer
    output reg rsp_valid,
    output reg [`ASC_DATA_W-1:0] rsp_rdata,
    // Memory pins
    output reg [`ASC_ADDR_W-1:0] word_address,
    output reg chip_sel_n,
    output reg out_en_n,
    output reg write_en_n,
    input wire [`ASC_DATA_W-1:0] data_bus_in,
    output reg [`ASC_DATA_W-1:0] data_bus_out,
    output reg data_bus_oe
);
    // Cycle counts are worked out at full width first.
    localparam integer RC_F_W = `ASC_CYC_MIN(`ASC_T_RC_FAST);
    localparam integer RC_S_W = `ASC_CYC_MIN(`ASC_T_RC_SLOW);
    localparam integer OE_F_W = `ASC_CYC_MIN(`ASC_T_OE_FAST);
    localparam integer OE_S_W = `ASC_CYC_MIN(`ASC_T_OE_SLOW);
    localparam integer CHZ_F_W = `ASC_CYC_MIN(`ASC_T_CHZ_FAST);
    localparam integer CHZ_S_W = `ASC_CYC_MIN(`ASC_T_CHZ_SLOW);
    localparam integer WP_F_W = `ASC_CYC_MIN(`ASC_T_WP_FAST);
    localparam integer WP_S_W = `ASC_CYC_MIN(`ASC_T_WP_SLOW);
    localparam integer WHZ_F_W = `ASC_CYC_MIN(`ASC_T_WHZ_FAST);
    localparam integer WHZ_S_W = `ASC_CYC_MIN(`ASC_T_WHZ_SLOW);
    localparam integer OHZ_C_W = `ASC_CYC_MIN(`ASC_T_OHZ);
    localparam integer OW_C_W = `ASC_CYC_MIN(`ASC_T_OW);

    // The timer is four bits wide; every count fits, so the cut drops only zeros.
    localparam [3:0] RC_F = RC_F_W[3:0];
    localparam [3:0] RC_S = RC_S_W[3:0];
    localparam [3:0] OE_F = OE_F_W[3:0];
    localparam [3:0] OE_S = OE_S_W[3:0];
    localparam [3:0] CHZ_F = CHZ_F_W[3:0];
    localparam [3:0] CHZ_S = CHZ_S_W[3:0];
    localparam [3:0] WP_F = WP_F_W[3:0];
    localparam [3:0] WP_S = WP_S_W[3:0];
    localparam [3:0] WHZ_F = WHZ_F_W[3:0];
    localparam [3:0] WHZ_S = WHZ_S_W[3:0];
    localparam [3:0] OHZ_C = OHZ_C_W[3:0];
    localparam [3:0] OW_C = OW_C_W[3:0];

    // One-hot states.
    localparam [6:0] S_OFF = 7'h01;
    localparam [6:0] S_IDLE = 7'h02;
    localparam [6:0] S_READ = 7'h04;
    localparam [6:0] S_RREL = 7'h08;
    localparam [6:0] S_WTURN = 7'h10;
    localparam [6:0] S_WPULSE = 7'h20;
    localparam [6:0] S_WREC = 7'h40;

    reg [6:0] state;
    reg [6:0] next_state;
    reg load;
    reg [3:0] count;
    wire done;

    // Picks a timing count for the active grade.
    function [3:0] pick;
        input slow;
        input [3:0] fast_c;
        input [3:0] slow_c;
        begin
            pick = slow ? slow_c : fast_c;
        end
    endfunction

    asc_timer u_timer (
        .clk(clk),
        .rst(rst),
        .load(load),
        .count(count),
        .done(done)
    );

    // Ready only when idle, the supply is good and the recovery wait is over.
    assign req_ready = state[1] && done && supply_ok;

    // Next state and the length of the phase it starts.
    always @* begin
        next_state = state;
        load = 1'b0;
        count = 4'h0;
        case (state)
            S_OFF: begin
                // After supply returns, wait one read cycle before any access.
                if (supply_ok) begin
                    next_state = S_IDLE;
                    load = 1'b1;
                    count = pick(slow_grade, RC_F, RC_S);
                end
            end
            S_IDLE: begin
                if (!supply_ok) begin
                    next_state = S_OFF;
                end else if (req_valid && done) begin
                    load = 1'b1;
                    if (req_write) begin
                        // Device needs time to float its outputs before we drive.
                        next_state = S_WTURN;
                        count = pick(slow_grade, WHZ_F, WHZ_S);
                    end else begin
                        next_state = S_READ;
                        count = pick(slow_grade, RC_F, RC_S);
                    end
                end
            end
            S_READ: begin
                if (done) begin
                    // Hold off until the device has released the bus.
                    next_state = S_RREL;
                    load = 1'b1;
                    count = pick(slow_grade, CHZ_F, CHZ_S);
                end
            end
            S_RREL: begin
                if (done) begin
                    next_state = S_IDLE;
                end
            end
            S_WTURN: begin
                if (done) begin
                    next_state = S_WPULSE;
                    load = 1'b1;
                    count = pick(slow_grade, WP_F, WP_S);
                end
            end
            S_WPULSE: begin
                if (done) begin
                    // Recovery lasts the longer of the OW_C and OHZ_C counts.
                    next_state = S_WREC;
                    load = 1'b1;
                    count = OW_C > OHZ_C ? OW_C : OHZ_C;
                end
            end
            S_WREC: begin
                if (done) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_OFF;
            end
        endcase
    end

    // Pin drive and answer capture.
    always @(posedge clk) begin
        if (rst) begin
            state <= S_OFF;
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            write_en_n <= 1'b1;
            word_address <= 14'h0000;
            data_bus_out <= 4'h0;
            data_bus_oe <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 4'h0;
        end else begin
            state <= next_state;
            rsp_valid <= 1'b0;
            case (next_state)
                S_READ: begin
                    // Address, select and output enable all change on the same edge.
                    chip_sel_n <= 1'b0;
                    out_en_n <= 1'b0;
                    write_en_n <= 1'b1;
                    data_bus_oe <= 1'b0;
                end
                S_WTURN: begin
                    // Output enable high and write low first keeps device outputs off.
                    out_en_n <= 1'b1;
                    write_en_n <= 1'b0;
                    chip_sel_n <= 1'b1;
                    data_bus_oe <= 1'b0;
                end
                S_WPULSE: begin
                    chip_sel_n <= 1'b0;
                    data_bus_oe <= 1'b1;
                end
                S_WREC: begin
                    // Both strobes rise together; data stays driven for zero hold.
                    chip_sel_n <= 1'b1;
                    write_en_n <= 1'b1;
                end
                default: begin
                    chip_sel_n <= 1'b1;
                    out_en_n <= 1'b1;
                    write_en_n <= 1'b1;
                    data_bus_oe <= 1'b0;
                end
            endcase
            if (state[1] && next_state != S_IDLE && next_state != S_OFF) begin
                word_address <= req_addr;
                data_bus_out <= req_wdata;
            end
            // Sample at the end of the read cycle, after access time has passed.
            if (state[2] && done) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_bus_in;
            end
            if (state[5] && done) begin
                rsp_valid <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== core/asc_timer.v ====
`timescale 1ns/100ps
`default_nettype none
// Down counter that marks when a phase has lasted its cycle count.
module asc_timer (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire load,
    input wire [3:0] count,
    // Status
    output wire done
);
    reg [3:0] left;

    // Loading restarts the phase; the counter then runs down to zero.
    always @(posedge clk) begin
        if (rst) begin
            left <= 4'h0;
        end else if (load) begin
            left <= count;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end

    // Done looks only at the count, because the state machine loads on done.
    // Gating done with load here would close a combinational loop.
    assign done = (left == 4'h0);
endmodule
`default_nettype wire

// ==== tb/asc_host_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
// Runs reads and writes through the host against the memory model.
module asc_host_bench;
    logic clk, rst, slow_grade, supply_ok, req_valid, req_write;
    logic [13:0] req_addr, word_address;
    logic [3:0] req_wdata, rsp_rdata, data_bus_in, data_bus_out;
    logic req_ready, rsp_valid, chip_sel_n, out_en_n, write_en_n, data_bus_oe;
    int err_count, n_tests, cyc;
    asc_host DUT (.clk(clk), .rst(rst), .slow_grade(slow_grade), .supply_ok(supply_ok),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .word_address(word_address), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n), .data_bus_in(data_bus_in),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
    asc_sram_model mem (.slow(slow_grade), .word_address(word_address),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in));
    // Free running clock.
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // A hang is cut short well past the expected run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check4(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One request held until taken; reads compare the word against d.
    task automatic op(input logic wr, input logic [13:0] a, input logic [3:0] d);
        int n;
        @(negedge clk);
        req_valid = 1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        n = 0;
        #1;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            #1;
            n++;
        end
        check4("req_ready", 1, req_ready);
        @(negedge clk);
        req_valid = 0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check4("rsp_valid", 1, rsp_valid);
        if (!wr) check4("rsp_rdata", d, rsp_rdata);
    endtask
    // Both address ends, back to back.
    task automatic t_fast();
        op(1, 14'h0000, 4'hA);
        op(1, 14'h3FFF, 4'h5);
        op(0, 14'h0000, 4'hA);
        op(0, 14'h3FFF, 4'h5);
    endtask
    // Overwrite keeps only the last word.
    task automatic t_over();
        op(1, 14'h0007, 4'h3);
        op(1, 14'h0007, 4'h9);
        op(0, 14'h0007, 4'h9);
    endtask
    // Slow grade against a slow memory.
    task automatic t_slow();
        repeat (6) @(negedge clk);
        slow_grade = 1;
        op(1, 14'h1234, 4'hC);
        op(0, 14'h1234, 4'hC);
        repeat (6) @(negedge clk);
        slow_grade = 0;
    endtask
    // Supply loss refuses requests and keeps data.
    task automatic t_supply();
        repeat (6) @(negedge clk);
        supply_ok = 0;
        req_valid = 1;
        req_write = 0;
        repeat (3) @(negedge clk);
        #1;
        check4("req_ready", 0, req_ready);
        check4("chip_sel_n", 1, chip_sel_n);
        req_valid = 0;
        supply_ok = 1;
        op(0, 14'h0007, 4'h9);
    endtask
    // Reset for 12 cycles, then each scenario in turn.
    initial begin
        rst = 1;
        slow_grade = 0;
        supply_ok = 1;
        req_valid = 0;
        req_write = 0;
        req_addr = 0;
        req_wdata = 0;
        err_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (12) @(negedge clk);
        rst = 0;
        t_fast();
        t_over();
        t_slow();
        t_supply();
        stop_test();
    end
endmodule
`default_nettype wire

// ==== tb/asc_host_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// Pin rules for the host side, counted in 10 ns cycles.
module asc_host_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Modes
    input wire logic slow_grade,
    input wire logic supply_ok,
    // Memory pins
    input wire logic [13:0] word_address,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic [3:0] data_bus_out,
    input wire logic data_bus_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // The write pulse is the overlap of both strobes low.
    wire wr_ovl = !chip_sel_n && !write_en_n;
    // Pulse and address must stand for 20 ns or 30 ns.
    sequence wp_fast; (wr_ovl && $stable(word_address))[*2]; endsequence
    sequence wp_slow; (wr_ovl && $stable(word_address))[*3]; endsequence
    AST_READ_WE_HIGH: assert property (!chip_sel_n && !out_en_n |-> write_en_n)
        else $error("write low in read");
    AST_NO_CONTENTION: assert property (data_bus_oe |-> out_en_n)
        else $error("bus driven with output on");
    AST_WP_FAST: assert property ($rose(wr_ovl) && !slow_grade |-> wp_fast)
        else $error("short fast pulse");
    AST_WP_SLOW: assert property ($rose(wr_ovl) && slow_grade |-> wp_slow)
        else $error("short slow pulse");
    AST_DATA_VALID: assert property (wr_ovl |-> data_bus_oe && (!$past(wr_ovl) || $stable(data_bus_out)))
        else $error("write data not held");
    AST_ADDR_HELD: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(word_address))
        else $error("address moved while selected");
    AST_SUPPLY_DESEL: assert property (!supply_ok |-> ##[0:1] chip_sel_n)
        else $error("selected without supply");
    AST_SUPPLY_WAIT: assert property ($rose(supply_ok) |-> chip_sel_n[*3])
        else $error("access too soon after supply");
endmodule
bind asc_host asc_host_checker u_chk (.clk(clk), .rst(rst), .slow_grade(slow_grade),
    .supply_ok(supply_ok), .word_address(word_address), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe));
`default_nettype wire

// ==== tb/asc_sram_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behavioural memory; slow mode answers late but inside the access time.
module asc_sram_model (
    // Answer speed
    input wire logic slow,
    // Memory pins
    input wire logic [13:0] word_address,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic [3:0] data_bus_out,
    input wire logic data_bus_oe,
    output logic [3:0] data_bus_in
);
    logic [3:0] mem [0:16383];
    logic [3:0] dev_word;
    wire dev_on = !chip_sel_n && !out_en_n && write_en_n;
    wire wr_now = !chip_sel_n && !write_en_n && data_bus_oe;
    wire [3:0] cur_word = mem[word_address];
    // Storing through the overlap keeps the last value before the end.
    always @(wr_now or word_address or data_bus_out)
        if (wr_now) mem[word_address] = data_bus_out;
    // Read data lags just short of the access time, so an early sample sees stale bits.
    always @(cur_word) dev_word <= #(slow ? 34 : 24) cur_word;
    // A released bus shows the inverse, never a stale match.
    assign data_bus_in = data_bus_oe ? data_bus_out : dev_on ? dev_word : ~dev_word;
endmodule
`default_nettype wire
